/* File: time_hold_regs.sv */
// Package for the flags/control and time-sync block, plus the seven
// host-visible time holding registers.
// Assumes a single clock with a clock enable; reset already synchronised.
`default_nettype none

package rtc_pkg;
    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [14:0] ADDR_FLAGS      = 15'h7FF0;
    localparam logic [14:0] ADDR_ALM_FIRST  = 15'h7FF2;
    localparam logic [14:0] ADDR_ALM_LAST   = 15'h7FF5;
    localparam logic [14:0] ADDR_TIME_FIRST = 15'h7FF9;
    localparam logic [14:0] ADDR_TIME_LAST  = 15'h7FFF;
    localparam int          TIME_REGS       = 7;
    localparam int          ALM_REGS        = 4;
    localparam int          MASK_BIT        = 7;
    // Time register indices (7FF9h upward)
    localparam int IDX_SEC   = 0;
    localparam int IDX_MIN   = 1;
    localparam int IDX_HOUR  = 2;
    localparam int IDX_DAY   = 3;
    localparam int IDX_DATE  = 4;
    localparam int IDX_MONTH = 5;
    localparam int IDX_YEAR  = 6;
    // Timing, in 32.768 kHz timebase ticks
    localparam int TICKS_PER_SEC = 32768;
    localparam int CAL_HALF      = 32;
    // Field reset values
    localparam logic [7:0] TIME_RST = 8'h00;
    localparam logic [7:0] DATE_RST = 8'h01;

    typedef struct packed {
        logic watchdog_expired_flag;
        logic af;
        logic pf;
        logic cf;
    } flags_t;

    typedef struct packed {
        logic tst;
        logic cal;
        logic w;
        logic r;
    } ctrl_t;

    localparam flags_t FLAGS_RST = '0;
    localparam ctrl_t  CTRL_RST  = '0;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [14:0] addr;
        logic [7:0]  data;
    } host_bus_t;

    typedef logic [TIME_REGS-1:0][7:0] time_vec_t;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = v + 8'h01;
        end
    endfunction : bcd_inc
endpackage : rtc_pkg

module time_hold_regs
    import rtc_pkg::*;
(
    input  wire logic            mclk,
    input  wire logic            rst_sync_n,
    input  wire logic            clk_en,
    input  wire logic            wr_en,
    input  wire logic [2:0]      wr_idx,
    input  wire logic [7:0]      wr_data,
    input  wire logic            bulk_en,
    input  wire rtc_pkg::time_vec_t bulk_data,
    input  wire logic [2:0]      rd_idx,
    output logic [7:0]           rd_data,
    output rtc_pkg::time_vec_t   all_data
);
    genvar g;
    generate
        for (g = 0; g < TIME_REGS; g++) begin : g_reg
            always_ff @(posedge mclk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    all_data[g] <= TIME_RST;
                end else if (clk_en) begin
                    // Bulk refresh wins: host writes only stick while bulk_en is low (frozen, snapped or load cycle)
                    if (bulk_en) begin
                        all_data[g] <= bulk_data[g];
                    end else if (wr_en && wr_idx == 3'(g)) begin
                        all_data[g] <= wr_data;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_data <= 8'h00;
        end else if (clk_en) begin
            rd_data <= (rd_idx < 3'(TIME_REGS)) ? all_data[rd_idx] : 8'h00;
        end
    end
endmodule : time_hold_regs

`default_nettype wire

/* File: rtc_flags_sync.sv */
// Flags/control register, time snapshot and freeze-and-load path.
// Assumes host bus pins, timebase tick and supervisor events are
// synchronous to mclk.
`default_nettype none

module rtc_flags_sync
    import rtc_pkg::*;
#(
    parameter int TICKS_SEC = TICKS_PER_SEC
) (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               clk_en,
    input  wire rtc_pkg::host_bus_t host_bus,
    input  wire logic               tick_32k,
    input  wire logic               supply_low,
    input  wire logic               wdog_zero,
    output logic [7:0]              dq_out,
    output logic                    dq_oe_n,
    output logic                    cal_mode,
    output logic                    cal_wave,
    output logic                    test_mode
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_pipe_r;
    logic       rst_sync_n;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_r <= 2'b00;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_r[1];

    // ------------------------------------------------------------------
    // Host bus strobes
    // ------------------------------------------------------------------
    logic        rd_act, wr_act, rd_act_r, wr_act_r, wr_stb, rd_end;
    logic [14:0] rd_addr_r;
    logic        in_time, in_alm;
    flags_t      flags_r;
    ctrl_t       ctrl_r;
    logic        flag_rd;

    assign rd_act  = !host_bus.ce_n && !host_bus.oe_n && host_bus.we_n;
    assign wr_act  = !host_bus.ce_n && !host_bus.we_n;
    assign wr_stb  = wr_act && !wr_act_r;
    assign rd_end  = rd_act_r && !rd_act;
    assign in_time = host_bus.addr >= ADDR_TIME_FIRST && host_bus.addr <= ADDR_TIME_LAST;
    assign in_alm  = host_bus.addr >= ADDR_ALM_FIRST && host_bus.addr <= ADDR_ALM_LAST;
    // Clear at end of access so the host sees the flags it clears
    assign flag_rd = rd_end && rd_addr_r == ADDR_FLAGS;

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_act_r  <= 1'b0;
            wr_act_r  <= 1'b0;
            rd_addr_r <= 15'h0000;
        end else if (clk_en) begin
            rd_act_r <= rd_act;
            wr_act_r <= wr_act;
            if (rd_act && !rd_act_r) begin
                rd_addr_r <= host_bus.addr;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control bits and load request
    // ------------------------------------------------------------------
    logic load_r;

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_r <= CTRL_RST;
            load_r <= 1'b0;
        end else if (clk_en) begin
            load_r <= 1'b0;
            if (wr_stb && host_bus.addr == ADDR_FLAGS) begin
                // Flag bits are read-only: only low nibble stored
                ctrl_r <= ctrl_t'(host_bus.data[3:0]);
                load_r <= ctrl_r.w && !host_bus.data[1];
            end
        end
    end

    // ------------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------------
    logic [15:0] div_r;
    logic [5:0]  cal_cnt_r;
    logic        sec_tick, sec_tick_d_r;

    assign sec_tick = tick_32k && div_r == 16'(TICKS_SEC - 1);

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div_r        <= 16'h0000;
            sec_tick_d_r <= 1'b0;
        end else if (clk_en) begin
            sec_tick_d_r <= sec_tick;
            if (tick_32k) begin
                div_r <= sec_tick ? 16'h0000 : div_r + 16'h0001;
            end
        end
    end

    // Mode outputs; 512 Hz wave only runs in calibration mode
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cal_cnt_r <= 6'h00;
            cal_wave  <= 1'b0;
            cal_mode  <= 1'b0;
            test_mode <= 1'b0;
        end else if (clk_en) begin
            cal_mode  <= ctrl_r.cal;
            test_mode <= ctrl_r.tst;
            if (!ctrl_r.cal) begin
                cal_cnt_r <= 6'h00;
                cal_wave  <= 1'b0;
            end else if (tick_32k) begin
                if (cal_cnt_r == 6'(CAL_HALF - 1)) begin
                    cal_cnt_r <= 6'h00;
                    cal_wave  <= !cal_wave;
                end else begin
                    cal_cnt_r <= cal_cnt_r + 6'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Timekeeping counters
    // ------------------------------------------------------------------
    time_vec_t cnt_r, cnt_nxt, hold_all;
    logic      year_wrap;

    function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
        unique case (mon)
            8'h02:                      month_len = (yr[4] ^ yr[1] || yr[0]) ? 8'h28 : 8'h29;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default:                    month_len = 8'h31;
        endcase
    endfunction : month_len

    always_comb begin
        cnt_nxt   = cnt_r;
        year_wrap = 1'b0;
        if (sec_tick) begin
            if (cnt_r[IDX_SEC] != 8'h59) begin
                cnt_nxt[IDX_SEC] = bcd_inc(cnt_r[IDX_SEC]);
            end else begin
                cnt_nxt[IDX_SEC] = TIME_RST;
                if (cnt_r[IDX_MIN] != 8'h59) begin
                    cnt_nxt[IDX_MIN] = bcd_inc(cnt_r[IDX_MIN]);
                end else begin
                    cnt_nxt[IDX_MIN] = TIME_RST;
                    if (cnt_r[IDX_HOUR] != 8'h23) begin
                        cnt_nxt[IDX_HOUR] = bcd_inc(cnt_r[IDX_HOUR]);
                    end else begin
                        cnt_nxt[IDX_HOUR] = TIME_RST;
                        cnt_nxt[IDX_DAY]  = (cnt_r[IDX_DAY] == 8'h07) ? DATE_RST
                                                                       : bcd_inc(cnt_r[IDX_DAY]);
                        if (cnt_r[IDX_DATE] != month_len(cnt_r[IDX_MONTH], cnt_r[IDX_YEAR])) begin
                            cnt_nxt[IDX_DATE] = bcd_inc(cnt_r[IDX_DATE]);
                        end else begin
                            cnt_nxt[IDX_DATE] = DATE_RST;
                            if (cnt_r[IDX_MONTH] != 8'h12) begin
                                cnt_nxt[IDX_MONTH] = bcd_inc(cnt_r[IDX_MONTH]);
                            end else begin
                                cnt_nxt[IDX_MONTH] = DATE_RST;
                                if (cnt_r[IDX_YEAR] != 8'h99) begin
                                    cnt_nxt[IDX_YEAR] = bcd_inc(cnt_r[IDX_YEAR]);
                                end else begin
                                    cnt_nxt[IDX_YEAR] = TIME_RST;
                                    year_wrap         = 1'b1;
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cnt_r <= {TIME_RST, DATE_RST, DATE_RST, DATE_RST, TIME_RST, TIME_RST, TIME_RST};
        end else if (clk_en) begin
            // Load beats a same-cycle tick: host time is authoritative
            cnt_r <= load_r ? hold_all : cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Holding registers
    // ------------------------------------------------------------------
    logic [7:0] hold_rd;
    logic       bulk_en;

    // Track counters only while neither frozen nor snapped; the last
    // copy is the one taken in the cycle R rises, none after.
    // Skip the load cycle so the host bytes are not replaced by stale counts
    assign bulk_en = !ctrl_r.w && !ctrl_r.r && !load_r;

    time_hold_regs u_hold (
        .mclk       (mclk),
        .rst_sync_n (rst_sync_n),
        .clk_en     (clk_en),
        .wr_en      (wr_stb && in_time),
        .wr_idx     (host_bus.addr[2:0] - 3'h1),
        .wr_data    (host_bus.data),
        .bulk_en    (bulk_en),
        .bulk_data  (cnt_r),
        .rd_idx     (host_bus.addr[2:0] - 3'h1),
        .rd_data    (hold_rd),
        .all_data   (hold_all)
    );

    // ------------------------------------------------------------------
    // Alarm registers and match
    // ------------------------------------------------------------------
    logic [ALM_REGS-1:0][7:0] alm_r;
    logic                     alarm_hit;

    function automatic logic field_ok(input logic [7:0] alm, input logic [7:0] cur);
        field_ok = alm[MASK_BIT] || alm[6:0] == cur[6:0];
    endfunction : field_ok

    assign alarm_hit = field_ok(alm_r[0], cnt_r[IDX_SEC]) && field_ok(alm_r[1], cnt_r[IDX_MIN])
                    && field_ok(alm_r[2], cnt_r[IDX_HOUR])
                    && field_ok(alm_r[3], cnt_r[IDX_DATE]);

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            alm_r <= '0;
        end else if (clk_en && wr_stb && in_alm) begin
            alm_r[host_bus.addr[1:0] - 2'h2] <= host_bus.data;
        end
    end

    // ------------------------------------------------------------------
    // Sticky flags: a same-cycle event beats the read clear
    // ------------------------------------------------------------------
    logic supply_low_r;

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flags_r      <= FLAGS_RST;
            supply_low_r <= 1'b0;
        end else if (clk_en) begin
            supply_low_r <= supply_low;
            flags_r.af  <= (sec_tick_d_r && alarm_hit) || (flags_r.af && !flag_rd);
            flags_r.pf  <= (supply_low && !supply_low_r)
                        || (flags_r.pf && !flag_rd);
            flags_r.cf  <= year_wrap || (flags_r.cf && !flag_rd);
            flags_r.watchdog_expired_flag <= wdog_zero || (flags_r.watchdog_expired_flag && !flag_rd);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic rd_time_r;

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_time_r <= 1'b0;
            dq_out    <= 8'h00;
            dq_oe_n   <= 1'b1;
        end else if (clk_en) begin
            rd_time_r <= rd_act && in_time;
            dq_oe_n   <= !rd_act;
            if (rd_time_r) begin
                dq_out <= hold_rd;
            end else if (rd_act && host_bus.addr == ADDR_FLAGS) begin
                dq_out <= {flags_r, ctrl_r};
            end else if (rd_act && in_alm) begin
                dq_out <= alm_r[host_bus.addr[1:0] - 2'h2];
            end else if (!in_time) begin
                dq_out <= 8'h00;
            end
        end
    end
endmodule : rtc_flags_sync

`default_nettype wire

/* File: rtc_flags_sync_asserts.sv */
// Port-level checker for the flags/control and time-sync block.
// Assumes clk_en drops only between host accesses, one access at a time.
`default_nettype none
module rtc_flags_sync_asserts #(
    parameter int TICKS_SEC = rtc_pkg::TICKS_PER_SEC
) (
    input wire logic               mclk,
    input wire logic               rst_n,
    input wire logic               clk_en,
    input wire rtc_pkg::host_bus_t host_bus,
    input wire logic               tick_32k,
    input wire logic               supply_low,
    input wire logic               wdog_zero,
    input wire logic [7:0]         dq_out,
    input wire logic               dq_oe_n,
    input wire logic               cal_mode,
    input wire logic               cal_wave,
    input wire logic               test_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    import rtc_pkg::*;
    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire logic [14:0] a    = host_bus.addr;
    wire logic        rd   = clk_en && !host_bus.ce_n && !host_bus.oe_n && host_bus.we_n;
    wire logic        wr   = !host_bus.ce_n && !host_bus.we_n;
    wire logic        rdf  = rd && a == ADDR_FLAGS;
    wire logic        calm = !tick_32k && !wdog_zero;
    wire logic        hole = rd && a != ADDR_FLAGS && a < ADDR_TIME_FIRST
                             && !(a >= ADDR_ALM_FIRST && a <= ADDR_ALM_LAST);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_wr_ctl;
        wr && !$past(wr) && a == ADDR_FLAGS;
    endsequence
    sequence s_flag_rd;
        rdf [*3];
    endsequence
    // Flag clearing is judged only in reads with no tick, watchdog event or supply rise
    sequence s_calm_rd;
        (calm && !$rose(supply_low) && rdf) [*3];
    endsequence

    property p_drive_on;
        rd |=> !dq_oe_n;
    endproperty
    a_drive_on: assert property (p_drive_on) else $error("dq idle during read");
    property p_drive_off;
        !rd |=> dq_oe_n;
    endproperty
    a_drive_off: assert property (p_drive_off) else $error("dq driven outside read");
    property p_cal_follow;
        s_wr_ctl |-> ##2 cal_mode == $past(host_bus.data[2], 2);
    endproperty
    a_cal_follow: assert property (p_cal_follow) else $error("cal_mode wrong");
    property p_test_follow;
        s_wr_ctl |-> ##2 test_mode == $past(host_bus.data[3], 2);
    endproperty
    a_test_follow: assert property (p_test_follow) else $error("test_mode wrong");
    property p_wave_off;
        !cal_mode ##1 !cal_mode |-> !cal_wave;
    endproperty
    a_wave_off: assert property (p_wave_off) else $error("cal_wave outside cal");
    property p_wdog_flag;
        (wdog_zero && !rd) ##1 !rd ##1 s_flag_rd |-> dq_out[7];
    endproperty
    a_wdog_flag: assert property (p_wdog_flag) else $error("watchdog flag unset");
    property p_pf_flag;
        ($rose(supply_low) && !rd) ##1 !rd ##1 s_flag_rd |-> dq_out[5];
    endproperty
    a_pf_flag: assert property (p_pf_flag) else $error("power-fail flag unset");
    property p_flags_clr;
        s_calm_rd ##1 (calm && !rd) ##1 s_calm_rd |-> dq_out[7:4] == 4'h0;
    endproperty
    a_flags_clr: assert property (p_flags_clr) else $error("flags kept");
    property p_hole_zero;
        hole [*3] |-> dq_out == 8'h00;
    endproperty
    a_hole_zero: assert property (p_hole_zero) else $error("unmapped read not 00");
endmodule : rtc_flags_sync_asserts

bind rtc_flags_sync rtc_flags_sync_asserts #(.TICKS_SEC(TICKS_SEC)) i_chk (
    .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .host_bus(host_bus), .tick_32k(tick_32k),
    .supply_low(supply_low), .wdog_zero(wdog_zero), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .cal_mode(cal_mode), .cal_wave(cal_wave), .test_mode(test_mode)
);
`default_nettype wire

/* File: host_model.sv */
// Host processor model on the byte-wide bus.
// Assumes the bench calls one task at a time.
`default_nettype none
module host_model (
    input  wire logic               mclk,
    input  wire logic [7:0]         dq_out,
    input  wire logic               dq_oe_n,
    output var  rtc_pkg::host_bus_t host_bus
);
    timeunit 1ns;
    timeprecision 100ps;
    initial host_bus = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(posedge mclk);
        #2 host_bus = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, addr: a, data: d};
        @(posedge mclk);
        // Released data flips so a stale byte cannot pass for a write
        #2 host_bus = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: a, data: ~d};
    endtask : wr
    task automatic rd(input logic [14:0] a, input int hold, output logic [7:0] d);
        @(posedge mclk);
        #2 host_bus = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, addr: a, data: ~host_bus.data};
        repeat (hold) @(posedge mclk);
        // Undriven bus reads back inverted so a missing drive cannot pass
        #1 d = dq_oe_n ? ~dq_out : dq_out;
        #1 host_bus = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: a, data: host_bus.data};
    endtask : rd
endmodule : host_model
`default_nettype wire

/* File: tb_rtc_flags_sync.sv */
// Self-checking bench for the flags/control and time-sync block.
// Assumes the bound checker and host_model; ticks are placed by the bench.
`default_nettype none
module tb_rtc_flags_sync;
    timeunit 1ns;
    timeprecision 100ps;
    import rtc_pkg::*;
    localparam int TSEC = 4;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        tick_32k = 1'b0;
    logic        supply_low = 1'b0;
    logic        wdog_zero = 1'b0;
    logic        clk_en = 1'b1;
    host_bus_t   host_bus;
    logic [7:0]  dq_out;
    logic        dq_oe_n, cal_mode, cal_wave, test_mode;
    logic        wave_last = 1'b0;
    logic [31:0] lfsr = 32'h7011;
    int          failures = 0;
    int          samples_checked = 0;
    int          wave_flips = 0;

    initial begin
        forever #12.5 mclk = ~mclk;
    end
    rtc_flags_sync #(.TICKS_SEC(TSEC)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .host_bus(host_bus), .tick_32k(tick_32k),
        .supply_low(supply_low), .wdog_zero(wdog_zero), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .cal_mode(cal_mode), .cal_wave(cal_wave), .test_mode(test_mode)
    );
    host_model i_host (.mclk(mclk), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .host_bus(host_bus));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] to_bcd(input int n);
        return 8'((n / 10) * 16 + n % 10);
    endfunction : to_bcd
    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : next_rand
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask : chk
    // Flag reads keep the minimum hold so the checker sees them
    task automatic rd_chk(input string what, input logic [14:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic [7:0]  got;
        r = next_rand();
        i_host.rd(a, (a == ADDR_FLAGS) ? 3 : 3 + int'(r[1:0] % 3), got);
        chk(what, exp, got);
    endtask : rd_chk
    task automatic ticks(input int n);
        logic [31:0] r;
        for (int i = 0; i < n; i++) begin
            r = next_rand();
            repeat (1 + r[1:0]) @(posedge mclk);
            #2 tick_32k = 1'b1;
            @(posedge mclk);
            #2 tick_32k = 1'b0;
            if (cal_wave !== wave_last) wave_flips++;
            wave_last = cal_wave;
        end
    endtask : ticks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (100000) @(posedge mclk);
        failures++;
        report_and_stop();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [7:0]  s;
        logic [7:0]  roll [7];
        logic [7:0]  after [7];
        roll = '{8'h59, 8'h59, 8'h23, 8'h03, 8'h31, 8'h12, 8'h99};
        after = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h01, 8'h00};
        repeat (12) @(posedge mclk);
        #2 chk("dq_oe_n reset", 8'h01, {7'h0, dq_oe_n});
        chk("cal_mode reset", 8'h00, {7'h0, cal_mode});
        rst_n = 1'b1;
        repeat (3) @(posedge mclk);
        rd_chk("flags reset", ADDR_FLAGS, 8'h00);
        rd_chk("addr 7FF1", 15'h7FF1, 8'h00);
        rd_chk("addr 7FF8", 15'h7FF8, 8'h00);
        $display("test reset done");
        i_host.wr(ADDR_FLAGS, 8'hF4);
        rd_chk("flag write", ADDR_FLAGS, 8'h04);
        chk("cal_mode", 8'h01, {7'h0, cal_mode});
        chk("test_mode", 8'h00, {7'h0, test_mode});
        ticks(70);
        chk("cal_wave flips", 8'h01, {7'h0, wave_flips > 0});
        i_host.wr(ADDR_FLAGS, 8'h00);
        repeat (2) @(posedge mclk);
        #1 chk("cal_wave off", 8'h00, {6'h0, cal_mode, cal_wave});
        $display("test control done");
        @(posedge mclk);
        #2 wdog_zero = 1'b1;
        @(posedge mclk);
        #2 wdog_zero = 1'b0;
        rd_chk("wdog flag", ADDR_FLAGS, 8'h80);
        rd_chk("wdog clear", ADDR_FLAGS, 8'h00);
        @(posedge mclk);
        #2 supply_low = 1'b1;
        @(posedge mclk);
        rd_chk("pf flag", ADDR_FLAGS, 8'h20);
        rd_chk("pf clear", ADDR_FLAGS, 8'h00);
        supply_low = 1'b0;
        $display("test events done");
        for (int k = 0; k < 3; k++) begin
            r = next_rand();
            s = to_bcd(int'(r % 59));
            i_host.wr(ADDR_FLAGS, 8'h02);
            i_host.wr(ADDR_TIME_FIRST, s);
            ticks(2 * TSEC);
            rd_chk("frozen sec", ADDR_TIME_FIRST, s);
            i_host.wr(ADDR_FLAGS, 8'h00);
            rd_chk("loaded sec", ADDR_TIME_FIRST, s);
            ticks(TSEC);
            rd_chk("next sec", ADDR_TIME_FIRST, to_bcd(int'(r % 59) + 1));
        end
        $display("test load done");
        i_host.wr(ADDR_ALM_FIRST, 8'h00);
        for (int k = 1; k < ALM_REGS; k++) i_host.wr(ADDR_ALM_FIRST + 15'(k), 8'h80);
        i_host.wr(ADDR_FLAGS, 8'h02);
        for (int k = 0; k < TIME_REGS; k++) i_host.wr(ADDR_TIME_FIRST + 15'(k), roll[k]);
        i_host.wr(ADDR_FLAGS, 8'h00);
        ticks(TSEC);
        rd_chk("alarm century", ADDR_FLAGS, 8'h50);
        rd_chk("flags cleared", ADDR_FLAGS, 8'h00);
        for (int k = 0; k < TIME_REGS; k++) begin
            rd_chk("rolled time", ADDR_TIME_FIRST + 15'(k), after[k]);
        end
        $display("test rollover done");
        i_host.wr(ADDR_FLAGS, 8'h01);
        ticks(2 * TSEC);
        rd_chk("held sec", ADDR_TIME_FIRST, 8'h00);
        i_host.wr(ADDR_FLAGS, 8'h01);
        rd_chk("no recapture", ADDR_TIME_FIRST, 8'h00);
        i_host.wr(ADDR_FLAGS, 8'h00);
        i_host.wr(ADDR_FLAGS, 8'h01);
        rd_chk("new capture", ADDR_TIME_FIRST, 8'h02);
        rd_chk("held min", ADDR_TIME_FIRST + 15'h1, 8'h00);
        $display("test snapshot done");
        // Ticks while disabled must leave the counters alone
        i_host.wr(ADDR_FLAGS, 8'h00);
        repeat (2) @(posedge mclk);
        #2 clk_en = 1'b0;
        ticks(2 * TSEC);
        clk_en = 1'b1;
        rd_chk("enable low holds", ADDR_TIME_FIRST, 8'h02);
        $display("test enable done");
        report_and_stop();
    end
endmodule : tb_rtc_flags_sync
`default_nettype wire
